/* File: rtl/phy_dev_end.sv */
/*
 * Device end: utility bus register slave with per-port rate, loopback,
 * good-signal monitors and the receive timing marker pulse.
 * Assumes i_clk is the line reference clock and that the host keeps the
 * strobe sequence of the utility bus; all bus pins are asynchronous.
 * Bus strobes take effect two to three clocks after the pins move,
 * so each strobe phase must last at least four clocks.
 */
`include "port_map.svh"

module phy_dev_end import port_pkg::*; (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // Utility bus
  util_bus_if.dev         bus,
  // Receive bit streams, one per port
  input  wire logic [3:0] i_rx_bit,
  input  wire logic [3:0] i_rx_bit_en,
  // Per-port controls and status
  output logic [7:0]      o_port_mult,
  output logic [7:0]      o_port_loop,
  output logic [3:0]      o_good,
  output logic [3:0]      o_rx_fifo_en,
  // Timing marker pulse, active low
  output logic            o_rx_timing_marker_pulse_n
);
  port_ctl_t  ctl_reg [4];   // Per-port control
  logic [7:0] mctl_reg;      // Marker port and width
  logic [7:0] addr_reg;      // Latched register address
  logic [7:0] wdata_reg;     // Data seen during write
  logic [7:0] ad_s1;         // Line synchroniser, first stage
  logic [7:0] ad_s2;         // Line synchroniser, second stage
  logic [3:0] st_s1;         // Strobe synchroniser, first stage
  logic [3:0] st_s2;         // Strobes: ale, cs_n, rd_n, wr_n
  logic [3:0] st_d;          // Previous synchronised strobes
  logic [3:0] bit_s1, bit_s2;  // Receive bit synchroniser
  logic [3:0] en_s1, en_s2;    // Receive strobe synchroniser
  logic [3:0] good;          // Monitor good flags
  logic [3:0] marker;        // Monitor marker events
  logic [2:0] pulse_reg;     // Marker pulse cycles left
  logic       wr_act;        // Write qualifier now
  logic       wr_act_d;      // Write qualifier one clock ago
  logic       rd_act;        // Selected read qualifier

  // Write commit at an offset: qualifier has just ended
  function automatic logic commit_at(input logic [7:0] ofs);
    commit_at = wr_act_d && !wr_act && (addr_reg == ofs);
  endfunction

  // Two flip-flops on every asynchronous pin
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      // Idle levels: latch low, select and strobes high
      ad_s1  <= 8'h00;
      ad_s2  <= 8'h00;
      st_s1  <= 4'h7;
      st_s2  <= 4'h7;
      st_d   <= 4'h7;
      bit_s1 <= 4'h0;
      bit_s2 <= 4'h0;
      en_s1  <= 4'h0;
      en_s2  <= 4'h0;
    end else begin
      ad_s1  <= bus.ad;
      ad_s2  <= ad_s1;
      st_s1  <= {bus.ale, bus.cs_n, bus.rd_n, bus.wr_n};
      st_s2  <= st_s1;
      st_d   <= st_s2;
      bit_s1 <= i_rx_bit;
      bit_s2 <= bit_s1;
      en_s1  <= i_rx_bit_en;
      en_s2  <= en_s1;
    end
  end

  // Access qualifiers from synchronised strobes
  assign wr_act   = !st_s2[2] && !st_s2[0];
  assign wr_act_d = !st_d[2] && !st_d[0];
  assign rd_act   = !st_s2[2] && !st_s2[1] && !st_s2[3];

  // Address latch on falling latch strobe
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_reg <= 8'h00;
    end else if (st_d[3] && !st_s2[3]) begin
      // Address and strobes stem from one sampling edge
      addr_reg <= ad_s2;
    end
  end

  // Track write data while the write is active
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wdata_reg <= 8'h00;
    end else if (wr_act && !st_s2[3]) begin
      wdata_reg <= ad_s2;
    end
  end

  // Commit on write or chip select deasserting
  generate
    for (genvar p = 0; p < 4; p++) begin : g_ctl
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          ctl_reg[p] <= `PORT_CTL_RESET;
        end else if (commit_at(`OFS_PORT_CTL0 + 8'(p))) begin
          ctl_reg[p] <= wdata_reg;
        end
      end
      // Rate and loopback outputs; loopback without recovery is forced to recovery above 1x
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          o_port_mult[2*p +: 2] <= `MULT_1X;
          o_port_loop[2*p +: 2] <= `LOOP_OFF;
        end else begin
          o_port_mult[2*p +: 2] <= ctl_reg[p].mult;
          // Loopback without recovery fails above 1x
          if (ctl_reg[p].loop == `LOOP_NO_RECOVER && ctl_reg[p].mult != `MULT_1X) begin
            o_port_loop[2*p +: 2] <= `LOOP_RECOVER;
          end else begin
            o_port_loop[2*p +: 2] <= ctl_reg[p].loop;
          end
        end
      end
      // Symbol monitor per port
      sym_monitor u_mon (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_bit    (bit_s2[p]),
        .i_bit_en (en_s2[p]),
        .o_good   (good[p]),
        .o_marker (marker[p])
      );
    end
  endgenerate

  // Marker control register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mctl_reg <= `MARKER_CTL_RESET;
    end else if (commit_at(`OFS_MARKER_CTL)) begin
      // Port select, width field and spare bits stored
      mctl_reg <= wdata_reg;
    end
  end

  // Read data and line enable
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bus.ad_dev    <= 8'h00;
      bus.ad_dev_oe <= 1'b0;
    end else begin
      // Drive only while a selected read is seen
      bus.ad_dev_oe <= rd_act;
      // Image of the register at the latched address
      case (addr_reg)
        8'h00, 8'h01, 8'h02, 8'h03: bus.ad_dev <= ctl_reg[addr_reg[1:0]];
        `OFS_GOOD_STATUS:           bus.ad_dev <= {4'h0, good};
        `OFS_MARKER_CTL:            bus.ad_dev <= mctl_reg;
        default:                    bus.ad_dev <= 8'h00;
      endcase
    end
  end

  // Status and receive FIFO enable follow good signal
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_good       <= 4'h0;
      o_rx_fifo_en <= 4'h0;
    end else begin
      o_good       <= good;
      // Receive FIFO runs only while the line is good
      o_rx_fifo_en <= good;
    end
  end

  // Marker pulse: width field plus one cycles
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pulse_reg                  <= 3'h0;
      o_rx_timing_marker_pulse_n <= 1'b1;
    end else if (marker[mctl_reg[`MPORT_LSB +: 2]]) begin
      pulse_reg                  <= mctl_reg[`MWIDTH_LSB +: 3];
      o_rx_timing_marker_pulse_n <= 1'b0;
    end else if (pulse_reg != 3'h0) begin
      // Hold low while cycles remain
      pulse_reg <= pulse_reg - 3'h1;
    end else begin
      o_rx_timing_marker_pulse_n <= 1'b1;
    end
  end
endmodule

/* File: rtl/port_map.svh */
/*
 * Register offsets, field positions, reset values and counts shared by
 * the utility bus device end, the host end and the symbol monitor.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef PORT_MAP_SVH
`define PORT_MAP_SVH

// Register offsets on the 8-bit utility bus
`define OFS_PORT_CTL0     8'h00
`define OFS_PORT_CTL3     8'h03
`define OFS_GOOD_STATUS   8'h04
`define OFS_MARKER_CTL    8'h05

// Port control fields
`define MULT_LSB          0
`define LOOP_LSB          2
`define PORT_CTL_RESET    8'h00

// Marker control fields: width field value N gives N+1 cycles
`define MPORT_LSB         0
`define MWIDTH_LSB        4
`define MARKER_CTL_RESET  8'h00

// Multiplier and loopback codes
`define MULT_1X           2'h0
`define MULT_2X           2'h1
`define MULT_4X           2'h2
`define LOOP_OFF          2'h0
`define LOOP_RECOVER      2'h1
`define LOOP_NO_RECOVER   2'h2

// Symbol codes and monitor thresholds (arbitrary values)
`define SYM_ESCAPE        5'h11
`define SYM_MARKER        5'h1F
`define GOOD_COUNT        4'h8
`define LOSS_COUNT        4'h4

// Cells per receive and transmit FIFO
`define FIFO_CELLS        3

// Host strobe phase length in clocks, covers the device synchroniser
`define PHASE_CYCLES      3'h4

`endif

/* File: rtl/port_pkg.sv */
/*
 * Types shared by the utility bus ends.
 * Assumes nothing beyond the map header.
 */
package port_pkg;
  // Host access sequencer states
  typedef enum logic [5:0] {
    H_IDLE  = 6'h01,
    H_ADDR  = 6'h02,
    H_ALEL  = 6'h04,
    H_STRB  = 6'h08,
    H_REL   = 6'h10,
    H_GAP   = 6'h20
  } host_state_t;

  // One port control register image
  typedef struct packed {
    logic [3:0] unused;
    logic [1:0] loop;
    logic [1:0] mult;
  } port_ctl_t;
endpackage

/* File: rtl/util_bus_if.sv */
/*
 * Utility bus between host end and device end.
 * Assumes a pull-up on the shared lines: undriven lines read high.
 */
interface util_bus_if;
  logic [7:0] ad_host;      // Host drive value
  logic       ad_host_oe;   // Host drives lines
  logic [7:0] ad_dev;       // Device drive value
  logic       ad_dev_oe;    // Device drives lines
  logic [7:0] ad;           // Resolved line level
  logic       ale;          // Address latch strobe
  logic       cs_n;         // Chip select
  logic       rd_n;         // Read strobe
  logic       wr_n;         // Write strobe

  // Resolve the shared lines from both enables
  assign ad = ad_dev_oe ? ad_dev : (ad_host_oe ? ad_host : 8'hFF);

  modport host (output ad_host, ad_host_oe, ale, cs_n, rd_n, wr_n, input ad);
  modport dev  (output ad_dev, ad_dev_oe, input ad, ale, cs_n, rd_n, wr_n);
endinterface

/* File: rtl/sym_monitor.sv */
/*
 * Per-port receive symbol monitor: 4b/5b framing, good signal, marker.
 * Assumes i_bit and i_bit_en are already synchronised to i_clk.
 */
`include "port_map.svh"
module sym_monitor (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // Received bit stream
  input  wire logic i_bit,
  input  wire logic i_bit_en,
  // Status
  output logic      o_good,
  output logic      o_marker
);
  logic [4:0] shift_reg;   // Last five bits
  logic [2:0] phase_reg;   // Bit position within symbol
  logic [3:0] ok_reg;      // Consecutive valid symbols
  logic [3:0] bad_reg;     // Consecutive invalid symbols
  logic       esc_reg;     // Previous symbol was escape
  logic [4:0] sym;         // Candidate symbol
  logic       sym_done;    // Symbol boundary this cycle

  // Legal symbols: sixteen data codes and the escape
  function automatic logic sym_valid(input logic [4:0] s);
    case (s)
      5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D,
      `SYM_ESCAPE: sym_valid = 1'b1;
      default:     sym_valid = 1'b0;
    endcase
  endfunction

  assign sym      = {shift_reg[3:0], i_bit};
  assign sym_done = i_bit_en && (phase_reg == 3'h4);

  // Shift in bits; an invalid symbol while hunting slips one bit
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      shift_reg <= 5'h00;
      phase_reg <= 3'h0;
    end else if (i_bit_en) begin
      shift_reg <= sym;
      if (sym_done && !sym_valid(sym) && !o_good) begin
        phase_reg <= 3'h1;
      end else if (sym_done) begin
        phase_reg <= 3'h0;
      end else begin
        phase_reg <= phase_reg + 3'h1;
      end
    end
  end

  // Count valid and invalid symbols at each boundary
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ok_reg  <= 4'h0;
      bad_reg <= 4'h0;
    end else if (sym_done && sym_valid(sym)) begin
      bad_reg <= 4'h0;
      if (ok_reg != `GOOD_COUNT) begin
        ok_reg <= ok_reg + 4'h1;
      end
    end else if (sym_done) begin
      ok_reg <= 4'h0;
      if (bad_reg != `LOSS_COUNT) begin
        bad_reg <= bad_reg + 4'h1;
      end
    end
  end

  // Good signal on any valid stream, lost after repeated errors
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_good <= 1'b0;
    end else if (ok_reg == `GOOD_COUNT) begin
      o_good <= 1'b1;
    end else if (bad_reg == `LOSS_COUNT) begin
      o_good <= 1'b0;
    end
  end

  // Escape followed by marker symbol while good gives a one-cycle marker event
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      esc_reg  <= 1'b0;
      o_marker <= 1'b0;
    end else begin
      o_marker <= sym_done && esc_reg && (sym == `SYM_MARKER) && o_good;
      if (sym_done) begin
        esc_reg <= (sym == `SYM_ESCAPE);
      end
    end
  end
endmodule

/* File: rtl/phy_host_end.sv */
/*
 * Host end: sequences utility bus reads and writes from a simple
 * request port. Assumes the device synchronises strobes in two flops.
 */
`include "port_map.svh"
module phy_host_end import port_pkg::*; (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // Utility bus
  util_bus_if.host        bus,
  // Request port
  input  wire logic       i_req,
  input  wire logic       i_we,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  // Answer port
  output logic            o_busy,
  output logic [7:0]      o_rdata,
  output logic            o_rdata_valid
);
  host_state_t state_reg;    // Sequencer state
  logic [2:0]  cnt_reg;      // Phase counter
  logic        we_reg;       // Access is a write
  logic [7:0]  addr_reg;     // Target address
  logic [7:0]  data_reg;     // Write data, adjusted
  logic [3:0]  mult_nz_reg;  // Shadow: ports above 1x
  logic [7:0]  wdata_fix;    // Write data after safety fixes
  logic        any_fast;     // Some port above 1x
  logic        phase_end;    // Current phase elapsed

  assign any_fast  = |mult_nz_reg[3:0];
  assign phase_end = (cnt_reg == `PHASE_CYCLES);

  // Adjust loopback and marker width for fast ports
  always_comb begin
    wdata_fix = i_wdata;
    if (i_addr <= `OFS_PORT_CTL3 && i_wdata[`MULT_LSB +: 2] != `MULT_1X &&
        i_wdata[`LOOP_LSB +: 2] == `LOOP_NO_RECOVER) begin
      wdata_fix[`LOOP_LSB +: 2] = `LOOP_RECOVER;
    end
    if (i_addr == `OFS_MARKER_CTL && any_fast && i_wdata[`MWIDTH_LSB +: 3] == 3'h0) begin
      wdata_fix[`MWIDTH_LSB +: 3] = 3'h1;
    end
  end

  // Shadow of which ports run above 1x
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mult_nz_reg <= 4'h0;
    end else if (state_reg == H_IDLE && i_req && i_we && i_addr <= `OFS_PORT_CTL3) begin
      mult_nz_reg[i_addr[1:0]] <= (i_wdata[`MULT_LSB +: 2] != `MULT_1X);
    end
  end

  // Access sequencer
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= H_IDLE;
      cnt_reg   <= 3'h0;
      we_reg    <= 1'b0;
      addr_reg  <= 8'h00;
      data_reg  <= 8'h00;
    end else begin
      cnt_reg <= phase_end ? 3'h0 : cnt_reg + 3'h1;
      case (state_reg)
        H_IDLE: begin
          cnt_reg <= 3'h0;
          if (i_req) begin
            we_reg    <= i_we;
            addr_reg  <= i_addr;
            data_reg  <= wdata_fix;
            state_reg <= H_ADDR;
          end
        end
        H_ADDR:  if (phase_end) state_reg <= H_ALEL;
        H_ALEL:  if (phase_end) state_reg <= H_STRB;
        H_STRB:  if (phase_end) state_reg <= H_REL;
        H_REL:   if (phase_end) state_reg <= H_GAP;
        H_GAP:   if (phase_end) state_reg <= H_IDLE;
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  // Bus pins driven from flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bus.ale        <= 1'b0;
      bus.cs_n       <= 1'b1;
      bus.rd_n       <= 1'b1;
      bus.wr_n       <= 1'b1;
      bus.ad_host    <= 8'h00;
      bus.ad_host_oe <= 1'b0;
    end else begin
      bus.ale  <= (state_reg == H_ADDR) && !phase_end;
      bus.cs_n <= !((state_reg == H_STRB) && !phase_end);
      bus.rd_n <= !((state_reg == H_STRB) && !phase_end && !we_reg);
      bus.wr_n <= !((state_reg == H_STRB) && !phase_end && we_reg);
      bus.ad_host <= (state_reg == H_ADDR || state_reg == H_ALEL) ? addr_reg : data_reg;
      bus.ad_host_oe <= (state_reg == H_ADDR) || (state_reg == H_ALEL) ||
                        (we_reg && (state_reg == H_STRB || state_reg == H_REL));
    end
  end

  // Read capture near the end of the strobe
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata       <= 8'h00;
      o_rdata_valid <= 1'b0;
      o_busy        <= 1'b0;
    end else begin
      o_busy        <= (state_reg != H_IDLE) || i_req;
      o_rdata_valid <= (state_reg == H_STRB) && phase_end && !we_reg;
      if ((state_reg == H_STRB) && phase_end && !we_reg) begin
        o_rdata <= bus.ad;
      end
    end
  end
endmodule

/* File: bench/quad_phy_bus_props.sv */
/*
 * Checker for the utility bus between host end and device end.
 * Assumes plain inputs wired to the bus interface signals by name.
 */
module quad_phy_bus_props (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_nrst,
  // Bus signals
  input wire logic [7:0] ad_host,
  input wire logic       ad_host_oe,
  input wire logic [7:0] ad_dev,
  input wire logic       ad_dev_oe,
  input wire logic [7:0] ad,
  input wire logic       ale,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // One domain for every property
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // Never both ends on the lines
  a_no_contention: assert property (!(ad_dev_oe && ad_host_oe))
    else $error("both ends drive the shared lines");
  // Strobes never both active
  a_strobe_excl: assert property (rd_n || wr_n)
    else $error("read and write strobes low together");
  // Read and write strobes under chip select
  a_cs_strobe: assert property ((!rd_n || !wr_n) |-> !cs_n)
    else $error("strobe without chip select");
  // Latch strobe low through data phase
  a_strobe_ale_low: assert property ((!rd_n || !wr_n) |-> !ale)
    else $error("latch strobe high during data phase");
  // Latch strobe held long enough for the synchroniser
  a_ale_len: assert property ($rose(ale) |-> ale [*4])
    else $error("latch strobe pulse too short");
  // Address steady on the lines at the latching edge
  a_addr_at_latch: assert property ($fell(ale) |-> ad_host_oe && $stable(ad_host))
    else $error("address not held at latch edge");
  // Host releases lines for a read
  a_read_release: assert property (!rd_n |-> !ad_host_oe)
    else $error("host drives lines during read");
  // Device answers a read within the synchroniser delay
  a_dev_answer: assert property ($fell(rd_n) |-> ##[2:5] ad_dev_oe)
    else $error("device did not drive read data");
  // Device drives only for a selected read
  a_dev_cause: assert property ($rose(ad_dev_oe) |-> !cs_n && !rd_n && !ale)
    else $error("device drove lines without a read");
  // Device lets go after the read strobe ends
  a_dev_letgo: assert property ($rose(rd_n) |-> ##[1:5] !ad_dev_oe)
    else $error("device kept driving after read");
  // Write data held while strobe low
  a_wr_data_hold: assert property ((!wr_n && $past(!wr_n)) |-> ad_host_oe && $stable(ad_host))
    else $error("write data changed during strobe");

  // Main scenarios reached
  c_read: cover property ($rose(ad_dev_oe));
  c_write: cover property ($rose(wr_n));
  c_latch: cover property ($fell(ale));
endmodule

/* File: bench/test_quad_phy_host_port_rate_ctl.sv */
/*
 * Testbench joining host end and device end over the utility bus.
 * Assumes the map header and package of the design are compiled first.
 */
`include "port_map.svh"
module test_quad_phy_host_port_rate_ctl import port_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;
  logic       i_clk;              // 25 MHz clock
  logic       i_nrst;             // Reset, active low
  logic       i_req;              // Host request
  logic       i_we;               // Write request
  logic [7:0] i_addr;             // Request address
  logic [7:0] i_wdata;            // Request data
  logic       o_busy;             // Host busy
  logic [7:0] o_rdata;            // Read data
  logic       o_rdata_valid;      // Read data pulse
  logic [3:0] rx_bit;             // Received bits
  logic [3:0] rx_bit_en;          // Bit strobes
  logic [7:0] o_port_mult;        // Multipliers
  logic [7:0] o_port_loop;        // Loopback codes
  logic [3:0] o_good;             // Good signal
  logic [3:0] o_rx_fifo_en;       // Receive FIFO enables
  logic       o_rx_timing_marker_pulse_n; // Marker pulse
  logic [7:0] rd;                 // Last read byte
  int         n_fail;             // Mismatch count
  int         total_checks;       // Comparison count
  // Valid symbol table, MSB first on the line
  logic [4:0] valid_syms [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                                  5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

  util_bus_if i_util_bus_if ();
  phy_dev_end i_phy_dev_end (.i_clk(i_clk), .i_nrst(i_nrst), .bus(i_util_bus_if.dev),
    .i_rx_bit(rx_bit), .i_rx_bit_en(rx_bit_en), .o_port_mult(o_port_mult),
    .o_port_loop(o_port_loop), .o_good(o_good), .o_rx_fifo_en(o_rx_fifo_en),
    .o_rx_timing_marker_pulse_n(o_rx_timing_marker_pulse_n));
  phy_host_end i_phy_host_end (.i_clk(i_clk), .i_nrst(i_nrst), .bus(i_util_bus_if.host),
    .i_req(i_req), .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata), .o_busy(o_busy),
    .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid));
  quad_phy_bus_props i_quad_phy_bus_props (.i_clk(i_clk), .i_nrst(i_nrst),
    .ad_host(i_util_bus_if.ad_host), .ad_host_oe(i_util_bus_if.ad_host_oe),
    .ad_dev(i_util_bus_if.ad_dev), .ad_dev_oe(i_util_bus_if.ad_dev_oe),
    .ad(i_util_bus_if.ad), .ale(i_util_bus_if.ale), .cs_n(i_util_bus_if.cs_n),
    .rd_n(i_util_bus_if.rd_n), .wr_n(i_util_bus_if.wr_n));

  // Clock generator
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Compare one value and count it
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // One bus access through the host request port
  task automatic access(input logic we, input logic [7:0] addr, input logic [7:0] wdata);
    int n;
    n = 0;
    @(posedge i_clk);
    i_req   <= 1'b1;
    i_we    <= we;
    i_addr  <= addr;
    i_wdata <= wdata;
    @(posedge i_clk);
    i_req <= 1'b0;
    @(negedge i_clk);
    // Wait for the sequencer to return to idle
    while (o_busy && n < 100) begin
      if (o_rdata_valid) rd = o_rdata;
      @(negedge i_clk);
      n++;
    end
    if (n >= 100) begin
      $display("MISMATCH access completion expected idle seen busy");
      n_fail++;
    end
  endtask

  // Read helper that also compares
  task automatic rd_chk(input string what, input logic [7:0] addr, input logic [7:0] exp);
    rd = ~exp;
    access(1'b0, addr, 8'h00);
    check(what, exp, rd);
  endtask

  // Send one symbol on port 0, one bit a clock
  task automatic send_sym(input logic [4:0] sym);
    for (int i = 4; i >= 0; i--) begin
      @(posedge i_clk);
      rx_bit[0]    <= sym[i];
      rx_bit_en[0] <= 1'b1;
    end
  endtask

  // Reset values of outputs and registers
  task automatic test_reset();
    @(negedge i_clk);
    check("mult", 8'h00, o_port_mult);
    check("loop", 8'h00, o_port_loop);
    check("good", 8'h00, {4'h0, o_good});
    check("fifo en", 8'h00, {4'h0, o_rx_fifo_en});
    check("pulse", 8'h01, {7'h00, o_rx_timing_marker_pulse_n});
    for (int a = 0; a < 6; a++) rd_chk("reg reset", 8'(a), 8'h00);
    access(1'b1, 8'h3C, 8'h5A);
    rd_chk("unmapped", 8'h3C, 8'h00);
    $display("test_reset done");
  endtask

  // Every multiplier code on every port, loopback limited above 1x
  task automatic test_mult();
    logic [1:0] lp;
    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < 4; p++) begin
        lp = (m == 0) ? `LOOP_NO_RECOVER : `LOOP_RECOVER;
        access(1'b1, `OFS_PORT_CTL0 + 8'(p), {4'hA, `LOOP_NO_RECOVER, 2'(m)});
        rd_chk("ctl readback", `OFS_PORT_CTL0 + 8'(p), {4'hA, lp, 2'(m)});
        check("mult out", 8'(m), {6'h00, o_port_mult[2*p+:2]});
        check("loop out", {6'h00, lp}, {6'h00, o_port_loop[2*p+:2]});
      end
    end
    $display("test_mult done");
  endtask

  // Good signal from a stream that starts with one invalid symbol
  task automatic test_good();
    send_sym(5'h03);
    for (int i = 0; i < 40; i++) send_sym(valid_syms[i % 16]);
    // Stop the bit strobe so framing and status hold
    @(posedge i_clk);
    rx_bit_en[0] <= 1'b0;
    @(negedge i_clk);
    check("good", 8'h01, {4'h0, o_good});
    check("fifo en", 8'h01, {4'h0, o_rx_fifo_en});
    access(1'b1, `OFS_GOOD_STATUS, 8'hFF);
    rd_chk("status", `OFS_GOOD_STATUS, 8'h01);
    $display("test_good done");
  endtask

  // Width bumped on fast ports, then a timed marker pulse
  task automatic test_marker();
    int lows;
    lows = 0;
    access(1'b1, `OFS_MARKER_CTL, 8'h00);
    rd_chk("width bump", `OFS_MARKER_CTL, 8'h10);
    access(1'b1, `OFS_MARKER_CTL, 8'h30);
    rd_chk("marker ctl", `OFS_MARKER_CTL, 8'h30);
    fork
      begin
        send_sym(`SYM_ESCAPE);
        send_sym(`SYM_MARKER);
        for (int i = 0; i < 4; i++) send_sym(valid_syms[i]);
        @(posedge i_clk);
        rx_bit_en[0] <= 1'b0;
      end
      repeat (40) begin
        @(negedge i_clk);
        if (o_rx_timing_marker_pulse_n === 1'b0) lows++;
      end
    join
    check("pulse cycles", 8'h04, 8'(lows));
    $display("test_marker done");
  endtask

  // Loss of signal clears good and the FIFO enable
  task automatic test_loss();
    check("good before loss", 8'h01, {4'h0, o_good});
    for (int i = 0; i < 8; i++) send_sym(5'h00);
    @(posedge i_clk);
    rx_bit_en[0] <= 1'b0;
    repeat (4) @(negedge i_clk);
    check("good", 8'h00, {4'h0, o_good});
    check("fifo en", 8'h00, {4'h0, o_rx_fifo_en});
    rd_chk("status", `OFS_GOOD_STATUS, 8'h00);
    $display("test_loss done");
  endtask

  // Counts and verdict, then stop
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    n_fail = 0;
    total_checks = 0;
    rd = 8'h00;
    i_nrst = 1'b0;
    i_req = 1'b0;
    i_we = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    rx_bit = 4'h0;
    rx_bit_en = 4'h0;
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk);
    test_reset();
    test_mult();
    test_good();
    test_marker();
    test_loss();
    report_and_stop();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    $display("MISMATCH watchdog expected finish seen hang");
    report_and_stop();
  end
endmodule
